// ---- rtl/flash_host_ctrl.sv ----
// Host-side controller that drives a parallel asynchronous flash over its pins.
// Contract
// - Read holds select, gate low, strobe high.
// - Write drives strobe, select low, gate high.
// - Wait recovery delay before first read.
`include "flash_host_params.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int CLEAR_PULSE_MIN_NS = `CLEAR_PULSE_MIN_NS,
  parameter int CLEAR_TO_READ_DELAY_NS = `CLEAR_TO_READ_DELAY_NS,
  parameter int SELECT_ACCESS_TIME_NS = `SELECT_ACCESS_TIME_NS,
  parameter int READY_WAIT_NS = `READY_BUSY_NS,
  parameter int WRITE_PULSE_NS = `WRITE_PULSE_NS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire host_req_t req,
  input wire logic word_mode,
  output logic req_ready,
  output logic rsp_valid,
  output logic [`DATA_W-1:0] rsp_data,
  output logic rsp_timeout,
  output logic busy_seen,
  output ctl_pins_t pins,
  output logic [`ADDR_W-1:0] addr_out,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe,
  output logic top_data_or_low_addr_out,
  output logic top_data_or_low_addr_oe,
  input wire logic [`DATA_W-1:0] data_in,
  input wire logic ready_busy_out
);
  // Least times round up to whole cycles; the access window adds one cycle more.
  // timing from parameters
  localparam int PULSE_CYC = (CLEAR_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (CLEAR_TO_READ_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int ACCESS_RAW = (SELECT_ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int ACCESS_CYC = ACCESS_RAW + 1;
  localparam int WRITE_CYC = (WRITE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int READY_CYC = (READY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_WRITE, ST_WREC, ST_CLEAR, ST_WAITRDY, ST_RECOVER
  } state_t;

  state_t state_r, state_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  host_req_t cur_r;
  logic ready_sync;

  // Ready/busy is a pin from outside the clock domain.
  pin_sync3 #(.INIT(1'b1)) u_rdy_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(ready_busy_out),
    .level_out(ready_sync)
  );

  // Request decoding as named wires; a request is taken only while req_ready shows,
  // so the first edge after reset cannot swallow one that the user has not seen accepted.
  wire take_req = (state_r == ST_IDLE) && req_ready && req_valid;
  wire cnt_done = (cnt_r == '0);
  wire is_read = (req.op == `OP_READ);
  wire is_write = (req.op == `OP_WRITE);
  wire wait_over = ready_sync || cnt_done;

  // Next state; all timed phases count down to zero.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
    case (state_r)
      ST_IDLE: begin
        if (take_req) begin
          if (is_read) begin
            state_nxt = ST_READ;
            cnt_nxt = `CNT_W'(ACCESS_CYC - 1);
          end else if (is_write) begin
            state_nxt = ST_WRITE;
            cnt_nxt = `CNT_W'(WRITE_CYC - 1);
          end else begin
            state_nxt = ST_CLEAR;
            cnt_nxt = `CNT_W'(PULSE_CYC - 1);
          end
        end
      end
      ST_READ: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (cnt_done) begin
          state_nxt = ST_WREC;
        end
      end
      ST_WREC: begin
        state_nxt = ST_IDLE;
      end
      ST_CLEAR: begin
        if (cnt_done) begin
          state_nxt = ST_WAITRDY;
          cnt_nxt = `CNT_W'(READY_CYC);
        end
      end
      ST_WAITRDY: begin
        if (wait_over) begin
          state_nxt = ST_RECOVER;
          cnt_nxt = `CNT_W'(RECOVER_CYC - 1);
        end
      end
      ST_RECOVER: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Pin levels for the next cycle; idle means standby.
  wire nxt_sel = (state_nxt == ST_READ) || (state_nxt == ST_WRITE) || (state_nxt == ST_WREC);
  wire nxt_wr = (state_nxt == ST_WRITE);
  wire nxt_rd = (state_nxt == ST_READ);
  wire nxt_clr = (state_nxt == ST_CLEAR);
  wire nxt_drive = (state_nxt == ST_WRITE) || (state_nxt == ST_WREC);
  host_req_t cur_nxt;
  assign cur_nxt = take_req ? req : cur_r;
  wire byte_cfg = !word_mode;
  wire read_end = (state_r == ST_READ) && cnt_done;

  // State and request hold register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      cur_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cur_r <= cur_nxt;
    end
  end

  // Control pins, registered so each output comes from a flip-flop.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins <= '{select_n: 1'b1, out_gate_n: 1'b1, write_n: 1'b1, clear_n: 1'b1, word_sel: 1'b1};
    end else begin
      pins.select_n <= !nxt_sel;
      // read gate low, gate high otherwise
      pins.out_gate_n <= !nxt_rd;
      pins.write_n <= !nxt_wr;
      pins.clear_n <= !nxt_clr;
      pins.word_sel <= word_mode;
    end
  end

  // Address and data drive; byte mode moves the low address to the top data pin.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_out <= '0;
      data_out <= '0;
      data_oe <= 1'b0;
      top_data_or_low_addr_out <= 1'b0;
      top_data_or_low_addr_oe <= 1'b0;
    end else begin
      addr_out <= cur_nxt.addr;
      data_out <= byte_cfg ? {{(`DATA_W-`BYTE_W){1'b0}}, cur_nxt.wdata[`BYTE_W-1:0]} : cur_nxt.wdata;
      data_oe <= nxt_drive;
      top_data_or_low_addr_out <= byte_cfg ? cur_nxt.byte_low : cur_nxt.wdata[`DATA_W-1];
      top_data_or_low_addr_oe <= byte_cfg ? (state_nxt != ST_CLEAR) : nxt_drive;
    end
  end

  // Response capture at the end of the access window.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_timeout <= 1'b0;
      busy_seen <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      // plain read returns data; share timing
      rsp_valid <= read_end || ((state_r == ST_WREC)) || ((state_r == ST_RECOVER) && cnt_done);
      if (read_end) begin
        rsp_data <= byte_cfg ? {{(`DATA_W-`BYTE_W){1'b0}}, data_in[`BYTE_W-1:0]} : data_in;
      end
      if (state_r == ST_WAITRDY && wait_over) begin
        rsp_timeout <= !ready_sync;
      end
      // busy level is reported, not aborted
      busy_seen <= !ready_sync;
      req_ready <= (state_nxt == ST_IDLE);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/flash_host_params.svh ----
// Timing, width and encoding constants for the flash host controller.
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH
`define CLK_PERIOD_NS 50
`define ADDR_W 19
`define DATA_W 16
`define BYTE_W 8
`define CLEAR_PULSE_MIN_NS 500
`define CLEAR_TO_READ_DELAY_NS 50
`define SELECT_ACCESS_TIME_NS 90
`define READY_BUSY_NS 20000
`define WRITE_PULSE_NS 50
`define OP_READ 2'h0
`define OP_WRITE 2'h1
`define OP_CLEAR 2'h2
`define CNT_W 16
`define SYNC_IDLE 3'h7
`endif

// ---- rtl/flash_host_pkg.sv ----
// Types shared by the flash host controller.
`include "flash_host_params.svh"
package flash_host_pkg;
  // Host request carried from the user side.
  typedef struct packed {
    logic [1:0] op;
    logic [`ADDR_W-1:0] addr;
    logic byte_low;
    logic [`DATA_W-1:0] wdata;
  } host_req_t;
  // Control pin levels driven toward the flash.
  typedef struct packed {
    logic select_n;
    logic out_gate_n;
    logic write_n;
    logic clear_n;
    logic word_sel;
  } ctl_pins_t;
endpackage

// ---- rtl/pin_sync3.sv ----
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter logic INIT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_in,
  output var logic level_out
);
  logic [2:0] stage_r;
  // A change counts only once stages two and three agree.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage_r <= {3{INIT}};
      level_out <= INIT;
    end else begin
      stage_r <= {stage_r[1:0], pin_in};
      if (stage_r[1] == stage_r[2]) begin
        level_out <= stage_r[2];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/flash_host_assertions.sv ----
// Checker for the pin sequencing of the flash host controller.
`include "flash_host_params.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_host_assertions
  import flash_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire ctl_pins_t pins,
  input wire logic data_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // The clear pulse must span ten cycles, split to keep each repetition short.
  sequence clear_hold;
    !pins.clear_n [*8] ##1 !pins.clear_n [*2];
  endsequence
  // A read strobe of three cycles covers the select access time plus margin.
  sequence gate_hold;
    !pins.out_gate_n [*3];
  endsequence
  a_read_levels: assert property (!pins.select_n && !pins.out_gate_n |-> pins.write_n && pins.clear_n && !data_oe)
    else $error("read strobe levels wrong");
  a_write_levels: assert property (!pins.write_n |-> !pins.select_n && pins.out_gate_n && data_oe && pins.clear_n)
    else $error("write strobe levels wrong");
  a_read_hold: assert property ($fell(pins.out_gate_n) |-> gate_hold)
    else $error("read strobe too short");
  a_clear_width: assert property ($fell(pins.clear_n) |-> clear_hold)
    else $error("clear pulse too short");
  a_clear_recover: assert property ($rose(pins.clear_n) |-> pins.out_gate_n [*2])
    else $error("read too soon after clear");
endmodule
bind flash_host_ctrl flash_host_assertions i_chk (.sys_clk(sys_clk), .rst(rst), .pins(pins), .data_oe(data_oe));
`default_nettype wire

// ---- tb/flash_partner.sv ----
// Behavioural flash device seen from its pins.
`include "flash_host_params.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_partner
  import flash_host_pkg::*;
#(
  parameter int ACC_NS = 90,
  parameter int PROG_NS = 3000,
  parameter int CLR_BUSY_NS = 400
) (
  input wire ctl_pins_t pins,
  input wire logic [`ADDR_W-1:0] addr_out,
  input wire logic [`DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic top_out,
  output logic [`DATA_W-1:0] data_in,
  output var logic ready_busy_out
);
  // The array keeps data xor an address pattern, so unwritten words read a known value.
  bit [15:0] mem [0:524287];
  logic [15:0] junk = 16'h5a5a;
  logic [15:0] w;
  logic ok = 1'b0;
  logic rd;
  realtime done_at = 0.0;
  // Released pins show a changing pattern, so a stale value can never pass.
  always #25 junk = ~junk;
  // standby exit: data valid only after the full select access time.
  always @(pins.select_n) ok <= #(ACC_NS) !pins.select_n;
  // array reads gated by select, gate, strobe and clear.
  assign w = mem[addr_out] ^ addr_out[15:0] ^ 16'ha5a5;
  assign rd = ok && !pins.select_n && !pins.out_gate_n && pins.write_n && pins.clear_n;
  // width select: the top pin picks the byte, upper pins float.
  assign data_in[7:0] = !rd ? junk[7:0] : (pins.word_sel || !top_out) ? w[7:0] : w[15:8];
  assign data_in[15:8] = (rd && pins.word_sel) ? w[15:8] : junk[15:8];
  // write latch: captured on strobe rise, starts busy, ignored in clear.
  always @(posedge pins.write_n) if (!pins.select_n && pins.clear_n && data_oe) begin
    mem[addr_out] = {top_out, data_out[14:0]} ^ addr_out[15:0] ^ 16'ha5a5;
    ready_busy_out = 1'b0;
    done_at = $realtime + PROG_NS;
  end
  // busy survives deselect and a clear until the reset time ends.
  always @(negedge pins.clear_n) if (!ready_busy_out) done_at = 1.0e9;
  always @(posedge pins.clear_n) if (!ready_busy_out) done_at = $realtime + CLR_BUSY_NS;
  always #10 if ($realtime >= done_at) ready_busy_out = 1'b1;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench for the flash host controller.
`include "flash_host_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_host_pkg::*;
  logic sys_clk = 0, rst = 1, req_valid = 0, word_mode = 1;
  logic req_ready, rsp_valid, rsp_timeout, busy_seen, data_oe, top_out, top_oe, rb;
  host_req_t req = '0;
  ctl_pins_t pins;
  logic [`ADDR_W-1:0] addr_out;
  logic [15:0] rsp_data, data_out, data_in;
  logic [17:0] exp_q [$];
  int bad_count = 0, checked = 0;
  always #25 sys_clk = ~sys_clk;
  flash_host_ctrl #(.READY_WAIT_NS(1000)) i_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req(req), .word_mode(word_mode), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_timeout(rsp_timeout), .busy_seen(busy_seen), .pins(pins), .addr_out(addr_out), .data_out(data_out),
    .data_oe(data_oe), .top_data_or_low_addr_out(top_out), .top_data_or_low_addr_oe(top_oe),
    .data_in(data_in), .ready_busy_out(rb));
  flash_partner i_flash (.pins(pins), .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe),
    .top_out(top_out), .data_in(data_in), .ready_busy_out(rb));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Waits a falling edge first, so valid never falls and rises in one time step;
  // then holds the request until an edge takes it.
  task automatic send(input logic [1:0] op, input logic [`ADDR_W-1:0] a, input logic bl,
      input logic [15:0] wd, input logic [15:0] e);
    int n;
    n = 0;
    @(negedge sys_clk);
    exp_q.push_back({op, e});
    req = '{op, a, bl, wd};
    req_valid = 1'b1;
    do begin @(posedge sys_clk); n++; end while (req_ready !== 1'b1 && n < 2000);
    @(negedge sys_clk);
    req_valid = 1'b0;
    if (n >= 2000) begin bad_count++; tally_and_finish; end
  endtask
  // Bounded wait until every noted result has been seen.
  task automatic drain;
    int n;
    for (n = 0; exp_q.size() != 0 && n < 2000; n++) @(negedge sys_clk);
    if (n >= 2000) begin bad_count++; tally_and_finish; end
  endtask
  // Each response pulse retires the oldest note; writes carry no data to compare.
  always @(negedge sys_clk) if (rsp_valid === 1'b1) begin
    if (exp_q.size() == 0) chk("stray response", 16'h0001, 16'h0000);
    else if (exp_q[0][17:16] == `OP_READ) begin
      chk("rsp_data", rsp_data, exp_q[0][15:0]);
      chk("top_oe", {15'h0, top_oe}, {15'h0, !word_mode});
    end
    else if (exp_q[0][17:16] == `OP_CLEAR) chk("rsp_timeout", {15'h0, rsp_timeout}, exp_q[0][15:0]);
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  end
  initial begin
    logic [`ADDR_W-1:0] a;
    logic [15:0] w;
    int i;
    void'($urandom(32'h8236_e217));
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    // fresh device reads the array without any command.
    for (i = 0; i < 3; i++) begin a = 19'($urandom); send(`OP_READ, a, 1'b0, 16'h0, a[15:0] ^ 16'ha5a5); end
    drain;
    $display("test power-up reads done");
    // back-to-back word writes read back on all sixteen pins.
    for (i = 0; i < 3; i++) begin
      a = 19'($urandom);
      w = 16'($urandom);
      send(`OP_WRITE, a, 1'b0, w, 16'h0);
      send(`OP_READ, a, 1'b0, 16'h0, w);
    end
    drain;
    // The last program still runs after deselect, so busy must show.
    chk("busy_seen", {15'h0, busy_seen}, 16'h0001);
    $display("test word write and read done");
    // byte mode returns the byte picked by the low address, upper zero.
    word_mode = 1'b0;
    for (i = 0; i < 4; i++) begin
      a = 19'($urandom);
      w = a[15:0] ^ 16'ha5a5;
      send(`OP_READ, a, i[0], 16'h0, {8'h00, i[0] ? w[15:8] : w[7:0]});
    end
    drain;
    word_mode = 1'b1;
    $display("test byte reads done");
    // clear during a busy program, then an idle clear; array reads follow.
    a = 19'($urandom);
    w = 16'($urandom);
    send(`OP_WRITE, a, 1'b0, w, 16'h0);
    send(`OP_CLEAR, a, 1'b0, 16'h0, 16'h0000);
    send(`OP_READ, a ^ 19'h4_0000, 1'b0, 16'h0, a[15:0] ^ 16'ha5a5);
    send(`OP_CLEAR, a, 1'b0, 16'h0, 16'h0000);
    send(`OP_READ, a ^ 19'h4_0000, 1'b0, 16'h0, a[15:0] ^ 16'ha5a5);
    // the aborted program is restarted once the flash is ready, then read back.
    send(`OP_WRITE, a, 1'b0, w, 16'h0);
    send(`OP_READ, a, 1'b0, 16'h0, w);
    drain;
    $display("test hardware clear done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
